//--- include/gdp_pkg.sv
// What this block does
// [R1] Supply at or below stop level forces both gate drives low.
// [R2] Lockout releases only at start level or above, giving hysteresis.
// [R3] After lockout, low drive follows command; high drive waits command rising edge.
// [R4] Fault line held low while supply lockout is active.
// [R5] Supply dips shorter than about 3 us are filtered out.
// [R6] Current-limit flag rises after sense stays at limit for blanking time.
// [R7] Low drives follow their commands while current limit is flagged.
// [R8] Current-limit flag falls as soon as sense drops below limit.
// [R9] After high-side limit shutdown ends, high drive waits for command rising edge.
// [R10] High-side shutdown input ignores pulses shorter than about 3.3 us.
// [R11] Overcurrent trips after sense stays at trip level for blanking time.
// [R12] Trip turns all low drives off and pulls fault line low.
// [R13] Fault held low 25 us after trip, then drives follow commands.
// [R14] Controller stops motor on fault and waits 2 s before resuming; the host model resumes as soon as the fault line releases.
// [R15] Die over temperature shuts down all low drives.
// [R16] Thermal shutdown releases at release level or below; drives follow commands.
// [R17] Fault line held low during thermal shutdown.
// [R18] Any low fault line level, own or external, keeps low drives off.
// [R19] Controller forces low-side shutdown by pulling fault line low 6 us.
// [R20] Asserted high-side shutdown input turns off all high drives.
// [R21] Comparator flags arrive digital; times are counted on the clock.
package gdp_pkg;
  localparam int CLK_MHZ = 100;
  localparam int UV_FILTER_NS = 3000;
  localparam int LIMIT_BLANK_NS = 2000;
  localparam int TRIP_BLANK_NS = 2000;
  localparam int HOLD_NS = 25000;
  localparam int SD_FILTER_NS = 3300;
  localparam int UV_FILTER_CYC = UV_FILTER_NS * CLK_MHZ / 1000;
  localparam int LIMIT_BLANK_CYC = (LIMIT_BLANK_NS * CLK_MHZ + 999) / 1000;
  localparam int TRIP_BLANK_CYC = (TRIP_BLANK_NS * CLK_MHZ + 999) / 1000;
  localparam int HOLD_CYC = HOLD_NS * CLK_MHZ / 1000;
  localparam int SD_FILTER_CYC = SD_FILTER_NS * CLK_MHZ / 1000;
  localparam int CNT_W = 12;
  localparam logic [2:0] DRIVE_RST = 3'h0;

  typedef struct packed {
    logic below_stop;
    logic above_start;
    logic at_limit;
    logic at_trip;
    logic over_hot;
    logic below_release;
  } gdp_sense_t;

  typedef struct packed {
    logic [2:0] high;
    logic [2:0] low;
  } gdp_phase_t;
endpackage : gdp_pkg

//--- rtl/gdp_ctrl.sv
`timescale 1ns/1ps
module gdp_ctrl (
  input wire logic clk,
  input wire logic rst_n,
  input wire gdp_pkg::gdp_sense_t sense_in,
  input wire gdp_pkg::gdp_phase_t command_in,
  input wire logic high_side_shutdown_in,
  input wire logic fault_line_in,
  output gdp_pkg::gdp_phase_t gate_drive,
  output logic fault_line_out,
  output logic fault_line_oe,
  output logic current_limit_flag
);
  // ==========================================================
  // Reset release and input synchronisers
  logic [1:0] rst_pipe;
  logic rst_s_n;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) rst_pipe <= 2'h0;
    else rst_pipe <= {rst_pipe[0], 1'b1};
  end
  assign rst_s_n = rst_pipe[1];

  localparam int IN_W = 6 + 6 + 2;
  logic [IN_W-1:0] sync1, sync2;
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= {sense_in, command_in, high_side_shutdown_in, fault_line_in};
      sync2 <= sync1;
    end
  end
  gdp_pkg::gdp_sense_t sense;
  gdp_pkg::gdp_phase_t cmd;
  logic sd_raw, fault_ext_high;
  assign {sense, cmd, sd_raw, fault_ext_high} = sync2; // [R21]

  // ==========================================================
  // Supply lockout with filter and hysteresis
  logic uv_lock;
  logic [gdp_pkg::CNT_W-1:0] uv_cnt;
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      uv_lock <= 1'b1;
      uv_cnt <= '0;
    end else if (!uv_lock) begin
      // Short dips restart the filter, so they never lock out
      if (!sense.below_stop) uv_cnt <= '0; // [R5]
      else if (uv_cnt == gdp_pkg::CNT_W'(gdp_pkg::UV_FILTER_CYC - 1)) begin
        uv_lock <= 1'b1; // [R1]
        uv_cnt <= '0;
      end else uv_cnt <= uv_cnt + 1'b1;
    end else begin
      if (!sense.above_start) uv_cnt <= '0;
      else if (uv_cnt == gdp_pkg::CNT_W'(gdp_pkg::UV_FILTER_CYC - 1)) begin
        uv_lock <= 1'b0; // [R2]
        uv_cnt <= '0;
      end else uv_cnt <= uv_cnt + 1'b1;
    end
  end

  // ==========================================================
  // Current limit blanking
  logic [gdp_pkg::CNT_W-1:0] lim_cnt;
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      lim_cnt <= '0;
      current_limit_flag <= 1'b0;
    end else if (!sense.at_limit) begin
      lim_cnt <= '0;
      current_limit_flag <= 1'b0; // [R8]
    end else if (lim_cnt == gdp_pkg::CNT_W'(gdp_pkg::LIMIT_BLANK_CYC - 1)) begin
      current_limit_flag <= 1'b1; // [R6]
    end else lim_cnt <= lim_cnt + 1'b1;
  end

  // ==========================================================
  // Overcurrent trip with fixed hold
  logic [gdp_pkg::CNT_W-1:0] trip_cnt;
  logic [gdp_pkg::CNT_W-1:0] hold_cnt;
  logic trip_hold;
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      trip_cnt <= '0;
      hold_cnt <= '0;
      trip_hold <= 1'b0;
    end else if (trip_hold) begin
      trip_cnt <= '0;
      // Hold runs its full time even if the sense level drops
      if (hold_cnt == gdp_pkg::CNT_W'(gdp_pkg::HOLD_CYC - 1)) begin
        trip_hold <= 1'b0; // [R13]
        hold_cnt <= '0;
      end else hold_cnt <= hold_cnt + 1'b1;
    end else if (!sense.at_trip) trip_cnt <= '0;
    else if (trip_cnt == gdp_pkg::CNT_W'(gdp_pkg::TRIP_BLANK_CYC - 1)) begin
      trip_hold <= 1'b1; // [R11]
      trip_cnt <= '0;
    end else trip_cnt <= trip_cnt + 1'b1;
  end

  // ==========================================================
  // Thermal shutdown with hysteresis
  logic hot;
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) hot <= 1'b0;
    else if (sense.over_hot) hot <= 1'b1; // [R15]
    else if (sense.below_release) hot <= 1'b0; // [R16]
  end

  // ==========================================================
  // High-side shutdown input filter
  logic sd_on;
  logic [gdp_pkg::CNT_W-1:0] sd_cnt;
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      sd_on <= 1'b0;
      sd_cnt <= '0;
    end else if (sd_raw == sd_on) sd_cnt <= '0;
    else if (sd_cnt == gdp_pkg::CNT_W'(gdp_pkg::SD_FILTER_CYC - 1)) begin
      sd_on <= sd_raw; // [R10]
      sd_cnt <= '0;
    end else sd_cnt <= sd_cnt + 1'b1;
  end

  // ==========================================================
  // Fault line and gate drives
  logic own_fault;
  assign own_fault = uv_lock | trip_hold | hot; // [R4] [R12] [R17]
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      fault_line_out <= 1'b0;
      fault_line_oe <= 1'b1;
    end else begin
      fault_line_out <= 1'b0;
      fault_line_oe <= own_fault;
    end
  end

  logic low_block;
  // External pull-down counts as well as our own fault
  assign low_block = own_fault | !fault_ext_high; // [R18]

  logic [2:0] cmd_prev, high_arm;
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      cmd_prev <= gdp_pkg::DRIVE_RST;
      high_arm <= gdp_pkg::DRIVE_RST;
    end else begin
      cmd_prev <= cmd.high;
      for (int i = 0; i < 3; i++) begin
        // Re-arm only on a fresh rising edge once blockers clear
        if (uv_lock || sd_on) high_arm[i] <= 1'b0; // [R3] [R9]
        else if (cmd.high[i] && !cmd_prev[i]) high_arm[i] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) gate_drive <= '0;
    else begin
      gate_drive.high <= (uv_lock || sd_on) ? 3'h0 : (cmd.high & high_arm); // [R20]
      gate_drive.low <= low_block ? 3'h0 : cmd.low; // [R7]
    end
  end

  // ==========================================================
  // Checks
  property p_uv_drive;
    @(posedge clk) disable iff (!rst_s_n) uv_lock |=> gate_drive == '0;
  endproperty
  a_uv_drive: assert property (p_uv_drive) else $error("drive on during lockout"); // [R1]
  property p_uv_fault;
    @(posedge clk) disable iff (!rst_s_n) uv_lock |=> fault_line_oe;
  endproperty
  a_uv_fault: assert property (p_uv_fault) else $error("fault not low in lockout"); // [R4]
  property p_lim_fall;
    @(posedge clk) disable iff (!rst_s_n) !sense.at_limit |=> !current_limit_flag;
  endproperty
  a_lim_fall: assert property (p_lim_fall) else $error("limit flag stuck"); // [R8]
  property p_lim_rise;
    @(posedge clk) disable iff (!rst_s_n) current_limit_flag |-> $past(sense.at_limit);
  endproperty
  a_lim_rise: assert property (p_lim_rise) else $error("limit flag without sense"); // [R6]
  property p_trip_low;
    @(posedge clk) disable iff (!rst_s_n) trip_hold |=> gate_drive.low == 3'h0;
  endproperty
  a_trip_low: assert property (p_trip_low) else $error("low drive on after trip"); // [R12]
  property p_hold;
    @(posedge clk) disable iff (!rst_s_n) $rose(trip_hold) |-> trip_hold [*8];
  endproperty
  a_hold: assert property (p_hold) else $error("trip hold too short"); // [R13]
  // Separate count of the hold, so a hold cut short or run long cannot slip past
  logic [gdp_pkg::CNT_W-1:0] hold_len;
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) hold_len <= '0;
    else if (trip_hold) hold_len <= hold_len + 1'b1;
    else hold_len <= '0;
  end
  property p_hold_len;
    @(posedge clk) disable iff (!rst_s_n)
      $fell(trip_hold) |-> hold_len == gdp_pkg::CNT_W'(gdp_pkg::HOLD_CYC);
  endproperty
  a_hold_len: assert property (p_hold_len) else $error("trip hold length wrong"); // [R13]
  property p_hot;
    @(posedge clk) disable iff (!rst_s_n) hot |=> (gate_drive.low == 3'h0) && fault_line_oe;
  endproperty
  a_hot: assert property (p_hot) else $error("thermal shutdown not applied"); // [R17]
  property p_ext;
    @(posedge clk) disable iff (!rst_s_n) !fault_ext_high |=> gate_drive.low == 3'h0;
  endproperty
  a_ext: assert property (p_ext) else $error("low drive on with fault line low"); // [R18]
  property p_sd;
    @(posedge clk) disable iff (!rst_s_n) sd_on |=> gate_drive.high == 3'h0;
  endproperty
  a_sd: assert property (p_sd) else $error("high drive on during shutdown"); // [R20]
  property p_sd_rise;
    @(posedge clk) disable iff (!rst_s_n) $rose(sd_on) |-> $past(sd_raw, 8);
  endproperty
  a_sd_rise: assert property (p_sd_rise) else $error("shutdown pulse not filtered"); // [R10]
  c_trip: cover property (@(posedge clk) disable iff (!rst_s_n) $fell(trip_hold));
  c_lim: cover property (@(posedge clk) disable iff (!rst_s_n) $rose(current_limit_flag));
  c_uv: cover property (@(posedge clk) disable iff (!rst_s_n) $fell(uv_lock));
  c_hot: cover property (@(posedge clk) disable iff (!rst_s_n) $fell(hot));
endmodule : gdp_ctrl

//--- verification/gdp_host_model.sv
`timescale 1ns/1ps
// ==========================================
// Host controller: pull-up on the fault wire, phase commands
module gdp_host_model (
  input wire logic dev_oe,
  input wire logic dev_out,
  input wire logic host_pull,
  input wire logic stop_en,
  input wire gdp_pkg::gdp_phase_t cmd_req,
  output logic fault_wire,
  output gdp_pkg::gdp_phase_t command
);
  // Released wire rises through the pull-up; the host can pull it low too
  assign fault_wire = !((dev_oe && !dev_out) || host_pull);
  // Motor stopped while a fault shows
  assign command = (stop_en && !fault_wire) ? '0 : cmd_req;
endmodule : gdp_host_model

//--- verification/tb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin failures++; \
  $display("wrong value %s expected %h seen %h", n, e, g); end end
module tb_top;
  logic clk, rst_n, sd_in, host_pull, stop_en, f_wire, f_out, f_oe, lim;
  gdp_pkg::gdp_sense_t sense;
  gdp_pkg::gdp_phase_t cmd_req, cmd, drv;
  int failures = 0;
  int checked = 0;
  gdp_ctrl i_gdp_ctrl (.clk(clk), .rst_n(rst_n), .sense_in(sense), .command_in(cmd),
    .high_side_shutdown_in(sd_in), .fault_line_in(f_wire), .gate_drive(drv),
    .fault_line_out(f_out), .fault_line_oe(f_oe), .current_limit_flag(lim));
  gdp_host_model i_gdp_host_model (.dev_oe(f_oe), .dev_out(f_out),
    .host_pull(host_pull), .stop_en(stop_en), .cmd_req(cmd_req),
    .fault_wire(f_wire), .command(cmd));
  // ==========================================
  // Clock and helpers
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  // High side needs a fresh command edge after supply lockout or high-side shutdown
  task automatic rearm;
    cmd_req.high = 3'h0;
    cyc(6);
    cmd_req.high = 3'h7;
    cyc(6);
  endtask : rearm
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : give_verdict
  // ==========================================
  // Scenarios
  task automatic t_uv;
    `CHK("oe lockout", 1'b1, f_oe)
    `CHK("drive lockout", 6'h00, drv)
    `CHK("fault data", 1'b0, f_out)
    cyc(320);
    `CHK("oe free", 1'b0, f_oe)
    `CHK("low free", 3'h5, drv.low)
    `CHK("high no edge", 3'h0, drv.high)
    rearm();
    `CHK("high edge", 3'h7, drv.high)
    sense.below_stop = 1'b1;
    sense.above_start = 1'b0;
    cyc(100);
    sense.below_stop = 1'b0;
    sense.above_start = 1'b1;
    cyc(20);
    `CHK("short dip", 1'b0, f_oe)
    sense.below_stop = 1'b1;
    sense.above_start = 1'b0;
    cyc(320);
    `CHK("oe dip", 1'b1, f_oe)
    `CHK("drive dip", 6'h00, drv)
    sense.below_stop = 1'b0;
    cyc(400);
    `CHK("hysteresis", 1'b1, f_oe)
    sense.above_start = 1'b1;
    cyc(320);
    `CHK("oe back", 1'b0, f_oe)
    `CHK("high wait", 3'h0, drv.high)
    rearm();
    $display("test undervoltage done");
  endtask : t_uv
  task automatic t_limit;
    sense.at_limit = 1'b1;
    cyc(150);
    `CHK("limit blank", 1'b0, lim)
    cyc(60);
    `CHK("limit set", 1'b1, lim)
    `CHK("low in limit", 3'h5, drv.low)
    sense.at_limit = 1'b0;
    cyc(5);
    `CHK("limit clear", 1'b0, lim)
    $display("test limit done");
  endtask : t_limit
  task automatic t_sd;
    sd_in = 1'b1;
    cyc(200);
    sd_in = 1'b0;
    cyc(20);
    `CHK("sd short", 3'h7, drv.high)
    sd_in = 1'b1;
    cyc(340);
    `CHK("sd high off", 3'h0, drv.high)
    `CHK("sd low", 3'h5, drv.low)
    sd_in = 1'b0;
    cyc(340);
    `CHK("sd no edge", 3'h0, drv.high)
    rearm();
    `CHK("sd edge", 3'h7, drv.high)
    $display("test shutdown done");
  endtask : t_sd
  task automatic t_trip;
    stop_en = 1'b1;
    sense.at_trip = 1'b1;
    cyc(150);
    `CHK("trip blank", 1'b0, f_oe)
    cyc(60);
    `CHK("trip oe", 1'b1, f_oe)
    `CHK("trip low", 3'h0, drv.low)
    `CHK("host stopped", 3'h0, drv.high)
    sense.at_trip = 1'b0;
    cyc(2400);
    `CHK("hold", 1'b1, f_oe)
    cyc(150);
    `CHK("hold end", 1'b0, f_oe)
    `CHK("low resumes", 3'h5, drv.low)
    `CHK("high resumes", 3'h7, drv.high)
    stop_en = 1'b0;
    $display("test trip done");
  endtask : t_trip
  task automatic t_hot;
    sense.over_hot = 1'b1;
    sense.below_release = 1'b0;
    cyc(6);
    `CHK("hot oe", 1'b1, f_oe)
    `CHK("hot low", 3'h0, drv.low)
    sense.over_hot = 1'b0;
    cyc(20);
    `CHK("hot hold", 1'b1, f_oe)
    sense.below_release = 1'b1;
    // Low drive waits for the released fault wire to pass the synchronisers
    cyc(10);
    `CHK("cool oe", 1'b0, f_oe)
    `CHK("cool low", 3'h5, drv.low)
    host_pull = 1'b1;
    cyc(600);
    `CHK("ext low", 3'h0, drv.low)
    host_pull = 1'b0;
    cyc(6);
    `CHK("ext free", 3'h5, drv.low)
    $display("test thermal and external done");
  endtask : t_hot
  // ==========================================
  // Main sequence and hang guard
  initial begin
    rst_n = 1'b0;
    sd_in = 1'b0;
    host_pull = 1'b0;
    stop_en = 1'b0;
    sense = 6'h11;
    cmd_req = 6'h3d;
    cyc(2);
    rst_n = 1'b1;
    cyc(4);
    t_uv();
    t_limit();
    t_sd();
    t_trip();
    t_hot();
    give_verdict();
  end
  initial begin
    #500000;
    failures++;
    give_verdict();
  end
endmodule : tb_top
